// >>> cslc_pkg.sv
// Package of constants for the comparator latch control block
package cslc_pkg;

  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [3:0] OFS_LATCH_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS        = 4'h4;
  localparam logic [3:0] OFS_PIN_CONFIG    = 4'h8;

  // Latch control field positions
  localparam int BIT_CMP2_PIN_SRC   = 7;
  localparam int BIT_CMP1_PIN_SRC   = 6;
  localparam int BIT_CMP1_SET_EN    = 5;
  localparam int BIT_CMP2_RESET_EN  = 4;
  localparam int BIT_PULSE_SET      = 3;
  localparam int BIT_PULSE_RESET    = 2;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hfc;

  // Status field positions
  localparam int BIT_STAT_CMP1      = 0;
  localparam int BIT_STAT_CMP2      = 1;
  localparam int BIT_STAT_LATCH_Q   = 2;

  // Pin configuration field positions
  localparam int BIT_CMP1_PIN_OE    = 0;
  localparam int BIT_CMP2_PIN_OE    = 1;
  localparam int BIT_CMP1_PIN_DIR   = 2;
  localparam int BIT_CMP2_PIN_DIR   = 3;
  localparam logic [7:0] PINCFG_WRITE_MASK = 8'h0f;

  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] PINCFG_RESET = 8'h0c;
  localparam logic       LATCH_RESET  = 1'b0;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage

// >>> cslc_props.sv
// Checker of bus and latch behaviour for the comparator latch control
`timescale 1ns/1ps
`default_nettype none
module cslc_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Comparators and outputs
  input wire logic        cmp1_result_async,
  input wire logic        cmp2_result_async,
  input wire logic        cmp1_output_pin_oe,
  input wire logic        cmp2_output_pin_oe,
  input wire logic        latch_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted accesses, split by target
  wire ack    = !avs_waitrequest;
  wire wr_en  = avs_write && ack && avs_byteenable[0];
  wire ctl_wr = wr_en && avs_address == 4'h0;
  wire cfg_wr = wr_en && avs_address == 4'h8;
  wire ctl_rd = avs_read && ack && avs_address == 4'h0;
  wire bad_a  = avs_address != 4'h0 && avs_address != 4'h4 && avs_address != 4'h8;
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> ack; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer one cycle after request");
  property p_wait_one; ack |=> !ack; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  // Sync takes two edges, latch one more
  property p_set; $rose(latch_q) |-> $past(cmp1_result_async, 3) ||
    $past(ctl_wr && avs_writedata[3], 2); endproperty
  a_set: assert property (p_set) else $error("latch set without cause");
  property p_clr; $fell(latch_q) |-> $past(cmp2_result_async, 3) ||
    $past(ctl_wr && avs_writedata[2], 2); endproperty
  a_clr: assert property (p_clr) else $error("latch cleared without cause");
  property p_oe; $changed({cmp1_output_pin_oe, cmp2_output_pin_oe}) |-> $past(cfg_wr, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable moved without config write");
  property p_low; ctl_rd |-> avs_readdata[1:0] == 2'b00; endproperty
  a_low: assert property (p_low) else $error("low control bits not zero");
  property p_pulse; ctl_rd |-> avs_readdata[3:2] == 2'b00; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse bit read as one");
  property p_unmap; avs_read && ack && bad_a |-> avs_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Main scenarios
  c_set: cover property ($rose(latch_q));
  c_clr: cover property ($fell(latch_q));
  c_oe: cover property ($rose(cmp2_output_pin_oe));
endmodule
`default_nettype wire

// >>> cslc_sync.sv
// Two-stage synchroniser for the asynchronous comparator results
`timescale 1ns/1ps
`default_nettype none
module cslc_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous input and its synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

// >>> cslc_top.sv
// Comparator-driven set/reset latch control with Avalon-MM registers
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cslc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Raw analog comparator results
  input  wire logic        cmp1_result_async,
  input  wire logic        cmp2_result_async,
  // Comparator output pins
  output logic             cmp1_output_pin_o,
  output logic             cmp1_output_pin_oe,
  output logic             cmp2_output_pin_o,
  output logic             cmp2_output_pin_oe,
  // Latch state for other logic
  output logic             latch_q
);

  // Registers
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  pincfg_reg;
  logic [7:0]  pincfg_next;
  logic        latch_reg;
  logic        latch_next;
  logic        waitreq_reg;
  logic        waitreq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        pin1_o_reg;
  logic        pin1_oe_reg;
  logic        pin2_o_reg;
  logic        pin2_oe_reg;

  // Synchronised comparator results
  logic [1:0]  cmp_sync;
  wire         comparator_result_1;
  wire         comparator_result_2;

  // Decoded bus strobes
  wire         req;
  wire         take;
  wire         wr_take;
  wire         lane0_wr;
  wire         sel_ctrl;
  wire         sel_status;
  wire         sel_pincfg;
  wire         wr_ctrl;
  wire         wr_pincfg;
  wire [7:0]   wbyte;

  // Control fields
  wire         cmp2_pin_source_select;
  wire         cmp1_pin_source_select;
  wire         cmp1_latch_set_enable;
  wire         cmp2_latch_reset_enable;
  wire         pulse_latch_set;
  wire         pulse_latch_reset;

  // Pin configuration fields
  wire         cmp1_pin_output_enable;
  wire         cmp2_pin_output_enable;
  wire         cmp1_pin_direction;
  wire         cmp2_pin_direction;

  // Latch inputs
  wire         latch_set;
  wire         latch_reset;

  // Pin selections
  wire         pin1_value;
  wire         pin2_value;
  wire         pin1_drive;
  wire         pin2_drive;

  // Read word
  wire [7:0]   status_byte;
  wire [7:0]   pulse_mask;
  wire [7:0]   ctrl_readback;
  wire [31:0]  read_word;

  // Address match, shared by read and write decode
  function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] ofs);
    addr_is = (addr == ofs);
  endfunction

  // Pin drive decode, shared by both comparator pins
  function automatic logic pin_driven(input logic oe, input logic dir);
    pin_driven = oe & ~dir;
  endfunction

  // Comparators are analog, so both results are synchronised first
  cslc_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({cmp2_result_async, cmp1_result_async}),
    .sync_out (cmp_sync)
  );

  assign comparator_result_1 = cmp_sync[0];
  assign comparator_result_2 = cmp_sync[1];

  // Bus decode; one wait cycle per access keeps read data registered
  assign req        = avs_read | avs_write;
  assign take       = req & ~waitreq_reg;
  assign wr_take    = take & avs_write;
  assign lane0_wr   = wr_take & avs_byteenable[0];
  assign sel_ctrl   = addr_is(avs_address, cslc_pkg::OFS_LATCH_CONTROL);
  assign sel_status = addr_is(avs_address, cslc_pkg::OFS_STATUS);
  assign sel_pincfg = addr_is(avs_address, cslc_pkg::OFS_PIN_CONFIG);
  assign wr_ctrl    = lane0_wr & sel_ctrl;
  assign wr_pincfg  = lane0_wr & sel_pincfg;
  assign wbyte      = avs_writedata[7:0];

  // Control field extraction
  assign cmp2_pin_source_select  = ctrl_reg[cslc_pkg::BIT_CMP2_PIN_SRC];
  assign cmp1_pin_source_select  = ctrl_reg[cslc_pkg::BIT_CMP1_PIN_SRC];
  assign cmp1_latch_set_enable   = ctrl_reg[cslc_pkg::BIT_CMP1_SET_EN];
  assign cmp2_latch_reset_enable = ctrl_reg[cslc_pkg::BIT_CMP2_RESET_EN];
  assign pulse_latch_set         = ctrl_reg[cslc_pkg::BIT_PULSE_SET];
  assign pulse_latch_reset       = ctrl_reg[cslc_pkg::BIT_PULSE_RESET];

  // Pin configuration extraction; direction 1 means pin is an input
  assign cmp1_pin_output_enable  = pincfg_reg[cslc_pkg::BIT_CMP1_PIN_OE];
  assign cmp2_pin_output_enable  = pincfg_reg[cslc_pkg::BIT_CMP2_PIN_OE];
  assign cmp1_pin_direction      = pincfg_reg[cslc_pkg::BIT_CMP1_PIN_DIR];
  assign cmp2_pin_direction      = pincfg_reg[cslc_pkg::BIT_CMP2_PIN_DIR];

  // Control register next value
  always_comb
  begin
    ctrl_next = ctrl_reg;
    // Pulse bits live exactly one cycle, then hardware drops them
    ctrl_next[cslc_pkg::BIT_PULSE_SET]   = 1'b0;
    ctrl_next[cslc_pkg::BIT_PULSE_RESET] = 1'b0;
    if (wr_ctrl)
    begin
      // Writing 0 to a pulse bit leaves it clear and fires nothing
      ctrl_next = wbyte & cslc_pkg::CTRL_WRITE_MASK;
    end
  end

  // Pin configuration next value
  assign pincfg_next = wr_pincfg ? (wbyte & cslc_pkg::PINCFG_WRITE_MASK) : pincfg_reg;

  // Latch inputs; comparator terms only count when enabled
  assign latch_set   = (cmp1_latch_set_enable & comparator_result_1)
                     | pulse_latch_set;
  assign latch_reset = (cmp2_latch_reset_enable & comparator_result_2)
                     | pulse_latch_reset;

  // Reset dominates when both inputs are active, like a NOR latch held low
  always_comb
  begin
    latch_next = latch_reg;
    if (latch_reset)
    begin
      latch_next = 1'b0;
    end
    else if (latch_set)
    begin
      latch_next = 1'b1;
    end
  end

  // Pin sources; pin two may carry the inverted latch output
  assign pin1_value = cmp1_pin_source_select ? latch_reg : comparator_result_1;
  assign pin2_value = cmp2_pin_source_select ? ~latch_reg : comparator_result_2;

  // Pin is driven only with output enable set and direction as output
  assign pin1_drive = pin_driven(cmp1_pin_output_enable, cmp1_pin_direction);
  assign pin2_drive = pin_driven(cmp2_pin_output_enable, cmp2_pin_direction);

  // Status reads the synchronised comparators, never the pin level
  assign status_byte = {5'h00, latch_reg, comparator_result_2, comparator_result_1};

  // Pulse bits hidden on readback, so a read right after the write sees them clear
  assign pulse_mask = 8'(1 << cslc_pkg::BIT_PULSE_SET) | 8'(1 << cslc_pkg::BIT_PULSE_RESET);

  // Low bits are masked on write, forced here as well on readback
  assign ctrl_readback = ctrl_reg & cslc_pkg::CTRL_WRITE_MASK & ~pulse_mask;

  // Read mux; unmapped addresses read as zero
  assign read_word = sel_ctrl   ? {24'h000000, ctrl_readback} :
                     sel_status ? {24'h000000, status_byte} :
                     sel_pincfg ? {24'h000000, pincfg_reg} :
                                  32'h00000000;

  // Waitrequest drops for one cycle after a request is seen
  assign waitreq_next = ~(req & waitreq_reg);

  // Read data captured together with the waitrequest drop
  assign rdata_next = (avs_read & waitreq_reg) ? read_word : rdata_reg;

  // Bus-side registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      waitreq_reg <= 1'b1;
      rdata_reg   <= 32'h00000000;
    end
    else
    begin
      waitreq_reg <= waitreq_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Configuration and latch state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg   <= cslc_pkg::CTRL_RESET;
      pincfg_reg <= cslc_pkg::PINCFG_RESET;
      latch_reg  <= cslc_pkg::LATCH_RESET;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      pincfg_reg <= pincfg_next;
      latch_reg  <= latch_next;
    end
  end

  // Pin outputs registered so every port comes from a flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin1_o_reg  <= 1'b0;
      pin1_oe_reg <= 1'b0;
      pin2_o_reg  <= 1'b0;
      pin2_oe_reg <= 1'b0;
    end
    else
    begin
      pin1_o_reg  <= pin1_value;
      pin1_oe_reg <= pin1_drive;
      pin2_o_reg  <= pin2_value;
      pin2_oe_reg <= pin2_drive;
    end
  end

  // Port drive
  assign avs_readdata       = rdata_reg;
  assign avs_waitrequest    = waitreq_reg;
  assign cmp1_output_pin_o  = pin1_o_reg;
  assign cmp1_output_pin_oe = pin1_oe_reg;
  assign cmp2_output_pin_o  = pin2_o_reg;
  assign cmp2_output_pin_oe = pin2_oe_reg;
  assign latch_q            = latch_reg;

endmodule
`default_nettype wire

// >>> cslc_top_tb.sv
// Self-checking bench for the comparator latch control block
`timescale 1ns/1ps
`default_nettype none
module cslc_top_tb;
  // Design ports
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        cmp1_result_async, cmp2_result_async, latch_q;
  logic        cmp1_output_pin_o, cmp1_output_pin_oe, cmp2_output_pin_o, cmp2_output_pin_oe;
  int          miscompares = 0;
  int          checked = 0;
  cslc_top i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmp1_result_async,
    .cmp2_result_async, .cmp1_output_pin_o, .cmp1_output_pin_oe, .cmp2_output_pin_o,
    .cmp2_output_pin_oe, .latch_q);
  // Clock, 5 ns period
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access; held until the edge that samples waitrequest low, data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Room for latch and pin stages to update
  task automatic wt();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  // Comparator change: two sync edges, then latch and pins
  task automatic cmp(input logic c1, input logic c2);
    @(posedge clk);
    cmp1_result_async <= c1;
    cmp2_result_async <= c2;
    repeat (3) @(posedge clk);
    wt();
  endtask
  task automatic t_regs();
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0c);
    bus(1'b1, 4'hc, 32'hff);
    rd(4'hc, 32'h0);
    bus(1'b1, 4'h0, 32'hc3);
    rd(4'h0, 32'hc0);
    bus(1'b1, 4'h0, 32'h0);
  endtask
  task automatic t_cmp();
    cmp(1'b1, 1'b0);
    chk(32'(latch_q), 32'h0);
    rd(4'h4, 32'h1);
    bus(1'b1, 4'h0, 32'h20);
    wt();
    chk(32'(latch_q), 32'h1);
    cmp(1'b0, 1'b1);
    chk(32'(latch_q), 32'h1);
    bus(1'b1, 4'h0, 32'h30);
    wt();
    chk(32'(latch_q), 32'h0);
    rd(4'h4, 32'h2);
    cmp(1'b0, 1'b0);
  endtask
  task automatic t_pulse();
    bus(1'b1, 4'h0, 32'h08);
    rd(4'h0, 32'h0);
    chk(32'(latch_q), 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    wt();
    chk(32'(latch_q), 32'h1);
    bus(1'b1, 4'h0, 32'h04);
    rd(4'h0, 32'h0);
    chk(32'(latch_q), 32'h0);
  endtask
  // Enables need both output enable and direction
  task automatic t_pins();
    bus(1'b1, 4'h8, 32'h0f);
    wt();
    chk({cmp1_output_pin_oe, cmp2_output_pin_oe}, 32'h0);
    bus(1'b1, 4'h8, 32'h0a);
    wt();
    chk({cmp1_output_pin_oe, cmp2_output_pin_oe}, 32'h0);
    bus(1'b1, 4'h8, 32'h03);
    wt();
    chk({cmp1_output_pin_oe, cmp2_output_pin_oe}, 32'h3);
    bus(1'b1, 4'h0, 32'h80);
    wt();
    chk(32'(cmp2_output_pin_o), 32'h1);
    cmp(1'b0, 1'b1);
    bus(1'b1, 4'h0, 32'h88);
    wt();
    chk(32'(cmp2_output_pin_o), 32'h0);
    rd(4'h4, 32'h6);
    bus(1'b1, 4'h0, 32'h0);
    wt();
    chk(32'(cmp2_output_pin_o), 32'h1);
    bus(1'b1, 4'h0, 32'h40);
    wt();
    chk(32'(cmp1_output_pin_o), 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    wt();
    chk(32'(cmp1_output_pin_o), 32'h0);
  endtask
  task automatic end_sim();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rst, avs_read, avs_write, cmp1_result_async, cmp2_result_async} = 5'h10;
    avs_address = 4'h0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cmp();
    t_pulse();
    t_pins();
    end_sim();
  end
  // Watchdog against a hung handshake
  initial
  begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule
bind cslc_top cslc_props i_props (.clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmp1_result_async,
  .cmp2_result_async, .cmp1_output_pin_oe, .cmp2_output_pin_oe, .latch_q);
`default_nettype wire
